// file: see_core.sv
// two-wire serial eeprom slave: 256 bytes, 16-byte page write, reads
// assumes scl/sda/wp/chip selects arrive asynchronously from pins
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.svh"
module see_core #(
  parameter int WR_TIME_NS = `SEE_WR_TIME_NS,
  parameter int FIFO_DEPTH = `SEE_FIFO_DEPTH
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic wp_i,
  input  wire logic chip_select_bit0_i,
  input  wire logic chip_select_bit1_i,
  input  wire logic chip_select_bit2_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      write_busy_o
);
  localparam int AW = `SEE_ADDR_W;
  localparam int DW = `SEE_DATA_W;
  localparam int PB = `SEE_PAGE_BYTES;
  localparam int PW = `SEE_PAGE_LSB_W;
  // a least time: round up to whole cycles
  localparam int WR_CYCLES = (WR_TIME_NS + `SEE_CLK_PERIOD_NS - 1) / `SEE_CLK_PERIOD_NS;

  // pin synchronisers
  see_pkg::see_pins_t raw_w;
  logic [5:0]         sy1_ff;
  logic [5:0]         sy2_ff;
  logic [5:0]         sy3_ff;
  logic [5:0]         filt_ff;
  logic [5:0]         prev_ff;
  see_pkg::see_pins_t pin_w;
  see_pkg::see_pins_t old_w;

  assign raw_w = '{scl: scl_i, sda: sda_i, wp: wp_i,
                   cs: {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i}};

  // a level counts once stages two and three agree, so one-sample glitches die
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sy1_ff[i]  <= 1'(`SEE_PIN_RST >> i);
        sy2_ff[i]  <= 1'(`SEE_PIN_RST >> i);
        sy3_ff[i]  <= 1'(`SEE_PIN_RST >> i);
        filt_ff[i] <= 1'(`SEE_PIN_RST >> i);
        prev_ff[i] <= 1'(`SEE_PIN_RST >> i);
      end else begin
        sy1_ff[i]  <= raw_w[i];
        sy2_ff[i]  <= sy1_ff[i];
        sy3_ff[i]  <= sy2_ff[i];
        if (sy2_ff[i] == sy3_ff[i]) filt_ff[i] <= sy3_ff[i];
        prev_ff[i] <= filt_ff[i];
      end
    end
  end

  assign pin_w = filt_ff;
  assign old_w = prev_ff;

  // bus events
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;

  assign scl_rise_w = pin_w.scl & ~old_w.scl;
  assign scl_fall_w = ~pin_w.scl & old_w.scl;
  assign start_w    = pin_w.scl & old_w.scl & old_w.sda & ~pin_w.sda;
  assign stop_w     = pin_w.scl & old_w.scl & ~old_w.sda & pin_w.sda;

  // state
  see_pkg::see_state_t state_ff;
  see_pkg::see_state_t nxt_state;
  logic [3:0]          bit_cnt_ff;
  logic [3:0]          nxt_bit_cnt;
  logic [DW-1:0]       rx_ff;
  logic [DW-1:0]       nxt_rx;
  logic [DW-1:0]       tx_ff;
  logic [DW-1:0]       nxt_tx;
  logic                oe_ff;
  logic                nxt_oe;
  logic [AW-1:0]       ptr_ff;
  logic [AW-1:0]       nxt_ptr;
  logic [AW-1:0]       fetch_ff;
  logic [AW-1:0]       nxt_fetch;
  logic                rd_dir_ff;
  logic                nxt_rd_dir;
  logic                rd_mode_ff;
  logic                nxt_rd_mode;
  logic                wr_pend_ff;
  logic                nxt_wr_pend;
  logic                mack_ff;
  logic                nxt_mack;
  logic                buf_we;
  logic                buf_clr;
  logic                pop;
  logic                flush;
  logic                commit;

  // write cycle
  logic          busy_ff;
  logic [31:0]   busy_cnt_ff;
  logic [PW:0]   prog_idx_ff;
  logic [AW-PW-1:0] page_ff;
  logic          blocked_ff;
  logic [PB-1:0] pbuf_valid_ff;
  logic [DW-1:0] pbuf_q [PB];
  logic [DW-1:0] mem_q  [1 << AW];

  // decode
  logic          byte_done_w;
  logic          ctrl_match_w;
  logic          prog_w;
  logic [PW-1:0] prog_sel_w;
  logic          fifo_in_ready_w;
  logic          fifo_out_valid_w;
  logic [DW-1:0] fifo_out_data_w;
  logic          push_w;
  logic [DW-1:0] load_byte_w;

  assign byte_done_w  = scl_fall_w & (bit_cnt_ff == `SEE_BITS_PER_BYTE);
  assign ctrl_match_w = (rx_ff[7:4] == `SEE_CTRL_CODE) & (rx_ff[3:1] == pin_w.cs) & ~busy_ff;
  assign prog_sel_w   = prog_idx_ff[PW-1:0];
  assign prog_w       = busy_ff & ~prog_idx_ff[PW] & pbuf_valid_ff[prog_sel_w] & ~blocked_ff;
  assign push_w       = rd_mode_ff & fifo_in_ready_w & ~flush;
  // dry prefetch sends ones, which reads as a released line
  assign load_byte_w  = fifo_out_valid_w ? fifo_out_data_w : `SEE_IDLE_BYTE;

  // prefetch lets the transmitter start a byte on the very scl fall;
  // fetcher stalls on a full buffer, the wire pace drains it
  see_fifo #(
    .W (DW),
    .D (FIFO_DEPTH)
  ) u_prefetch (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (flush),
    .in_valid_i  (push_w),
    .in_ready_o  (fifo_in_ready_w),
    .in_data_i   (mem_q[fetch_ff]),
    .out_valid_o (fifo_out_valid_w),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data_w)
  );

  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_rx      = rx_ff;
    nxt_tx      = tx_ff;
    nxt_oe      = oe_ff;
    nxt_ptr     = ptr_ff;
    nxt_fetch   = push_w ? fetch_ff + 1'b1 : fetch_ff;
    nxt_rd_dir  = rd_dir_ff;
    nxt_rd_mode = rd_mode_ff;
    nxt_wr_pend = wr_pend_ff;
    nxt_mack    = mack_ff;
    buf_we      = 1'b0;
    buf_clr     = 1'b0;
    pop         = 1'b0;
    flush       = 1'b0;
    commit      = 1'b0;
    if (start_w) begin
      // repeated start drops an unfinished write; pointer is kept
      nxt_state   = see_pkg::SEE_CTRL;
      nxt_bit_cnt = '0;
      nxt_oe      = 1'b0;
      nxt_wr_pend = 1'b0;
      nxt_rd_mode = 1'b0;
      flush       = 1'b1;
    end else if (stop_w) begin
      nxt_state   = see_pkg::SEE_IDLE;
      nxt_oe      = 1'b0;
      nxt_rd_mode = 1'b0;
      nxt_wr_pend = 1'b0;
      commit      = wr_pend_ff;
      flush       = 1'b1;
    end else begin
      case (state_ff)
        see_pkg::SEE_CTRL, see_pkg::SEE_ADDR, see_pkg::SEE_WDATA: begin
          if (scl_rise_w) begin
            nxt_rx      = {rx_ff[DW-2:0], pin_w.sda};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (byte_done_w) begin
            nxt_bit_cnt = '0;
            nxt_oe      = 1'b1;
            if (state_ff == see_pkg::SEE_CTRL) begin
              if (ctrl_match_w) begin
                nxt_state  = see_pkg::SEE_ACK_CTRL;
                nxt_rd_dir = rx_ff[0];
                if (rx_ff[0]) begin
                  nxt_rd_mode = 1'b1;
                  flush       = 1'b1;
                  nxt_fetch   = ptr_ff;
                end
              end else begin
                nxt_state = see_pkg::SEE_IDLE;
                nxt_oe    = 1'b0;
              end
            end else if (state_ff == see_pkg::SEE_ADDR) begin
              nxt_ptr   = rx_ff;
              buf_clr   = 1'b1;
              nxt_state = see_pkg::SEE_ACK_ADDR;
            end else begin
              buf_we      = 1'b1;
              nxt_ptr     = {ptr_ff[AW-1:PW], ptr_ff[PW-1:0] + 1'b1};
              nxt_wr_pend = 1'b1;
              nxt_state   = see_pkg::SEE_ACK_WR;
            end
          end
        end
        see_pkg::SEE_ACK_CTRL: begin
          if (scl_fall_w) begin
            if (rd_dir_ff) begin
              pop         = fifo_out_valid_w;
              nxt_tx      = load_byte_w;
              nxt_oe      = ~load_byte_w[DW-1];
              nxt_bit_cnt = 4'h1;
              nxt_ptr     = ptr_ff + 1'b1;
              nxt_state   = see_pkg::SEE_RDATA;
            end else begin
              nxt_oe    = 1'b0;
              nxt_state = see_pkg::SEE_ADDR;
            end
          end
        end
        see_pkg::SEE_ACK_ADDR, see_pkg::SEE_ACK_WR: begin
          if (scl_fall_w) begin
            nxt_oe    = 1'b0;
            nxt_state = see_pkg::SEE_WDATA;
          end
        end
        see_pkg::SEE_RDATA: begin
          if (scl_fall_w) begin
            if (bit_cnt_ff == `SEE_BITS_PER_BYTE) begin
              nxt_oe    = 1'b0;
              nxt_state = see_pkg::SEE_RACK;
            end else begin
              nxt_tx      = {tx_ff[DW-2:0], 1'b1};
              nxt_oe      = ~tx_ff[DW-2];
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        see_pkg::SEE_RACK: begin
          if (scl_rise_w) begin
            nxt_mack = ~pin_w.sda;
          end else if (scl_fall_w) begin
            if (mack_ff) begin
              pop         = fifo_out_valid_w;
              nxt_tx      = load_byte_w;
              nxt_oe      = ~load_byte_w[DW-1];
              nxt_bit_cnt = 4'h1;
              nxt_ptr     = ptr_ff + 1'b1;
              nxt_state   = see_pkg::SEE_RDATA;
            end else begin
              nxt_rd_mode = 1'b0;
              nxt_state   = see_pkg::SEE_IDLE;
            end
          end
        end
        default: begin
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff    <= see_pkg::SEE_IDLE;
      bit_cnt_ff  <= '0;
      rx_ff       <= '0;
      tx_ff       <= '0;
      oe_ff       <= 1'b0;
      ptr_ff      <= '0;
      fetch_ff    <= '0;
      rd_dir_ff   <= 1'b0;
      rd_mode_ff  <= 1'b0;
      wr_pend_ff  <= 1'b0;
      mack_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      rx_ff       <= nxt_rx;
      tx_ff       <= nxt_tx;
      oe_ff       <= nxt_oe;
      ptr_ff      <= nxt_ptr;
      fetch_ff    <= nxt_fetch;
      rd_dir_ff   <= nxt_rd_dir;
      rd_mode_ff  <= nxt_rd_mode;
      wr_pend_ff  <= nxt_wr_pend;
      mack_ff     <= nxt_mack;
    end
  end

  // page buffer: slot is the low pointer nibble, later bytes overwrite earlier
  always_ff @(posedge ref_clk_i) begin
    if (buf_we) pbuf_q[ptr_ff[PW-1:0]] <= rx_ff;
  end

  // valid bits cleared only by a new word address, never by a poll start
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pbuf_valid_ff <= '0;
    end else if (buf_clr) begin
      pbuf_valid_ff <= '0;
    end else if (buf_we) begin
      pbuf_valid_ff[ptr_ff[PW-1:0]] <= 1'b1;
    end
  end

  // busy for exactly the write cycle time, blocked writes included
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_ff     <= 1'b0;
      busy_cnt_ff <= '0;
      prog_idx_ff <= '0;
      page_ff     <= '0;
      blocked_ff  <= 1'b0;
    end else if (commit) begin
      busy_ff     <= 1'b1;
      busy_cnt_ff <= 32'(WR_CYCLES - 1);
      prog_idx_ff <= '0;
      page_ff     <= ptr_ff[AW-1:PW];
      blocked_ff  <= pin_w.wp & ptr_ff[AW-1];
    end else if (busy_ff) begin
      busy_cnt_ff <= busy_cnt_ff - 32'h0000_0001;
      if (busy_cnt_ff == '0) busy_ff <= 1'b0;
      if (!prog_idx_ff[PW]) prog_idx_ff <= prog_idx_ff + 1'b1;
    end
  end

  // array: one buffered byte per cycle, far shorter than the write time
  always_ff @(posedge ref_clk_i) begin
    if (prog_w) mem_q[{page_ff, prog_sel_w}] <= pbuf_q[prog_sel_w];
  end

  // outputs; open drain, so the data level is always low and only the enable moves
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_o        <= 1'b0;
      sda_oe_o     <= 1'b0;
      write_busy_o <= 1'b0;
    end else begin
      sda_o        <= 1'b0;
      sda_oe_o     <= nxt_oe;
      write_busy_o <= busy_ff;
    end
  end
endmodule : see_core
`default_nettype wire

// file: see_core_asserts.sv
// pin-level assertions for the eeprom slave: ack, busy and release timing
// assumes a bind onto see_core; sda_i is the resolved wire level
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.svh"
module see_core_asserts #(
  parameter int WR_TIME_NS = `SEE_WR_TIME_NS
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic wp_i,
  input wire logic chip_select_bit0_i,
  input wire logic chip_select_bit1_i,
  input wire logic chip_select_bit2_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_busy_o
);
  // write time is a least time, so partial cycles round up
  localparam int WR_CYC = (WR_TIME_NS + `SEE_CLK_PERIOD_NS - 1) / `SEE_CLK_PERIOD_NS;
  logic [3:0]  since_stop_ff;
  logic [3:0]  pulses_ff;
  logic [31:0] busy_cnt_ff;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_pin_stop;
    scl_i && $rose(sda_i);
  endsequence
  sequence s_bus_idle;
    scl_i && sda_i;
  endsequence

  // raw pins lead the device's filtered view by a few clocks
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      since_stop_ff <= 4'h0;
      pulses_ff     <= 4'h0;
      busy_cnt_ff   <= 32'h0000_0000;
    end else begin
      since_stop_ff <= (scl_i && $rose(sda_i)) ? 4'h0 : since_stop_ff + {3'h0, since_stop_ff != 4'hf};
      pulses_ff     <= (scl_i && $fell(sda_i)) ? 4'h0 : pulses_ff + {3'h0, $rose(scl_i) && pulses_ff != 4'hf};
      busy_cnt_ff   <= write_busy_o ? busy_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  a_sda_low_only: assert property (sda_o == 1'b0) else $error("data output value not low");
  a_no_ack_busy: assert property (write_busy_o |-> !sda_oe_o) else $error("pulled sda while busy");
  a_busy_length: assert property ($fell(write_busy_o) |-> busy_cnt_ff == WR_CYC)
    else $error("write cycle length wrong");
  a_busy_after_stop: assert property ($rose(write_busy_o) |-> since_stop_ff inside {[2:12]})
    else $error("busy without a stop");
  a_busy_bus_idle: assert property ($rose(write_busy_o) |-> s_bus_idle) else $error("busy with bus active");
  a_stop_release: assert property (s_pin_stop |-> !sda_oe_o [*4]) else $error("sda driven after stop");
  a_ack_after_ctrl: assert property ($rose(sda_oe_o) |-> pulses_ff >= 4'h8)
    else $error("sda driven inside control byte");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("sda changed with scl high");
endmodule : see_core_asserts
bind see_core see_core_asserts #(.WR_TIME_NS(WR_TIME_NS)) u_see_chk (
  .ref_clk_i          (ref_clk_i),
  .rst_b_i            (rst_b_i),
  .scl_i              (scl_i),
  .sda_i              (sda_i),
  .wp_i               (wp_i),
  .chip_select_bit0_i (chip_select_bit0_i),
  .chip_select_bit1_i (chip_select_bit1_i),
  .chip_select_bit2_i (chip_select_bit2_i),
  .sda_o              (sda_o),
  .sda_oe_o           (sda_oe_o),
  .write_busy_o       (write_busy_o)
);
`default_nettype wire

// file: see_core_tb.sv
// self-checking bench for the eeprom slave: selects, page write, protect, reads
// assumes see_master drives the link; the bench resolves the open-drain line
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.svh"
module see_core_tb;
  localparam int         WR_NS = 2000;  // 250 clocks keeps the run short
  localparam logic [2:0] CS    = 3'h5;
  logic       ref_clk;
  logic       rst_b;
  logic       wp;
  logic [2:0] cs;
  logic       scl_m;
  logic       sda_m;
  logic       sda_w;
  logic       sda_val;
  logic       sda_oe;
  logic       busy;
  int         err_count;
  int         checked;
  int         cyc;
  logic [7:0] exp_mem [256];

  assign sda_w = sda_m & ~(sda_oe & ~sda_val);

  see_core #(.WR_TIME_NS(WR_NS)) dut (
    .ref_clk_i          (ref_clk),
    .rst_b_i            (rst_b),
    .scl_i              (scl_m),
    .sda_i              (sda_w),
    .wp_i               (wp),
    .chip_select_bit0_i (cs[0]),
    .chip_select_bit1_i (cs[1]),
    .chip_select_bit2_i (cs[2]),
    .sda_o              (sda_val),
    .sda_oe_o           (sda_oe),
    .write_busy_o       (busy)
  );
  see_master mst (.scl_o(scl_m), .sda_o(sda_m), .sda_i(sda_w));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] ctl(input logic rd);
    return {`SEE_CTRL_CODE, CS, rd};
  endfunction : ctl

  task automatic wr_seq(input logic [7:0] a, input logic [7:0] d[$]);
    logic ack;
    int   n;
    mst.start();
    mst.wr_byte(ctl(1'b0), ack);
    check("write ctrl ack", 8'(ack), 8'h01);
    mst.wr_byte(a, ack);
    check("addr ack", 8'(ack), 8'h01);
    foreach (d[i]) begin
      mst.wr_byte(d[i], ack);
      check("data ack", 8'(ack), 8'h01);
      if (!(wp && a[7])) begin
        exp_mem[{a[7:4], 4'(a[3:0] + i)}] = d[i];
      end
    end
    mst.stop();
    repeat (20) @(negedge ref_clk);
    check("busy after stop", 8'(busy), 8'h01);
    n = 0;
    ack = 1'b0;
    while (!ack && n < 12) begin
      mst.start();
      mst.wr_byte(ctl(1'b0), ack);
      n++;
    end
    mst.stop();
    check("polls until ack", 8'(n), 8'h02);
  endtask : wr_seq

  task automatic rd_seq(input logic [7:0] a, input int n, input logic rnd);
    logic       ack;
    logic [7:0] d;
    if (rnd) begin
      mst.start();
      mst.wr_byte(ctl(1'b0), ack);
      mst.wr_byte(a, ack);
      check("random addr ack", 8'(ack), 8'h01);
    end
    mst.start();
    mst.wr_byte(ctl(1'b1), ack);
    check("read ctrl ack", 8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      mst.rd_byte(i < n - 1, d);
      check("read data", d, exp_mem[8'(a + i)]);
    end
    mst.stop();
    @(negedge ref_clk);
    check("released", 8'(sda_oe), 8'h00);
  endtask : rd_seq

  task automatic t_select();
    logic ack;
    for (int k = 0; k < 9; k++) begin
      mst.start();
      mst.wr_byte({(k < 8) ? `SEE_CTRL_CODE : 4'hb, (k < 8) ? 3'(k) : CS, 1'b0}, ack);
      mst.stop();
      check("select ack", 8'(ack), 8'(k < 8 && 3'(k) == CS));
      repeat (20) @(negedge ref_clk);
      check("no commit", 8'(busy), 8'h00);
    end
    $display("select test done");
  endtask : t_select

  // 18 bytes from 25h: wraps inside the page and overwrites 25h and 26h
  task automatic t_page();
    logic [7:0] d[$];
    for (int i = 0; i < 18; i++) d.push_back(8'h40 + 8'(i));
    wr_seq(8'h25, d);
    rd_seq(8'h20, 15, 1'b1);
    rd_seq(8'h2f, 1, 1'b0);
    $display("page test done");
  endtask : t_page

  task automatic t_protect();
    wr_seq(8'h80, {8'h11});
    @(negedge ref_clk);
    wp = 1'b1;
    wr_seq(8'h80, {8'haa});
    wr_seq(8'h7f, {8'h22});
    rd_seq(8'h7f, 2, 1'b1);
    @(negedge ref_clk);
    wp = 1'b0;
    $display("protect test done");
  endtask : t_protect

  task automatic t_roll();
    wr_seq(8'hff, {8'h5a});
    wr_seq(8'h00, {8'ha5});
    rd_seq(8'hff, 2, 1'b1);
    $display("rollover test done");
  endtask : t_roll

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    rst_b = 1'b0;
    wp = 1'b0;
    cs = CS;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (12) @(negedge ref_clk);
    t_select();
    t_page();
    t_protect();
    t_roll();
    results();
  end
endmodule : see_core_tb
`default_nettype wire

// file: see_defs.svh
// constants for the serial eeprom command layer: codes, sizes, timing counts
// assumes inclusion by bare name from the design files; definitions only
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH

// control byte: upper nibble that selects this device
`define SEE_CTRL_CODE      4'ha
// array and page geometry
`define SEE_ADDR_W         8
`define SEE_DATA_W         8
`define SEE_PAGE_BYTES     16
`define SEE_PAGE_LSB_W     4
// bits per byte on the wire, the ninth clock is the acknowledge
`define SEE_BITS_PER_BYTE  4'h8
// read prefetch buffer depth
`define SEE_FIFO_DEPTH     8
// own clock period and internal write cycle time, both in ns
`define SEE_CLK_PERIOD_NS  8
`define SEE_WR_TIME_NS     5000000
// filtered pin levels after reset: bus idle high, straps low
`define SEE_PIN_RST        6'h30
// value fed on byte when the prefetch ran dry
`define SEE_IDLE_BYTE      8'hff

`endif

// file: see_fifo.sv
// small synchronous fifo with valid/ready on both sides and a flush
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module see_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          push_w;
  logic          pop_w;

  assign in_ready_o  = (count_ff != (AW+1)'(D));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_q[rd_ptr_ff];
  assign push_w      = in_valid_i & in_ready_o & ~flush_i;
  assign pop_w       = out_valid_o & out_ready_i & ~flush_i;

  always_ff @(posedge ref_clk_i) begin
    if (push_w) begin
      mem_q[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (flush_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push_w) wr_ptr_ff <= (wr_ptr_ff == AW'(D-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop_w)  rd_ptr_ff <= (rd_ptr_ff == AW'(D-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule : see_fifo
`default_nettype wire

// file: see_master.sv
// two-wire bus master model: 125 ns link clock, open-drain data
// assumes the bench wire-ands sda_o with the device and a pull-up
`timescale 1ns/1ps
`default_nettype none
module see_master (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  localparam realtime Q = 31.25;

  // clock stands high outside frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic bit_xfer(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask : bit_xfer

  // also a repeated start when entered with scl low
  task automatic start();
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask : start

  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // ack high drives sda low to ask for the next byte, ack low leaves sda high to end the read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask : rd_byte
endmodule : see_master
`default_nettype wire

// file: see_pkg.sv
// types shared by the serial eeprom command layer
// assumes see_defs.svh holds the numeric constants
package see_pkg;

  // gray coded along write path, then read path
  typedef enum logic [3:0] {
    SEE_IDLE     = 4'h0,
    SEE_CTRL     = 4'h1,
    SEE_ACK_CTRL = 4'h3,
    SEE_ADDR     = 4'h2,
    SEE_ACK_ADDR = 4'h6,
    SEE_WDATA    = 4'h7,
    SEE_ACK_WR   = 4'h5,
    SEE_RDATA    = 4'h4,
    SEE_RACK     = 4'hc
  } see_state_t;

  // pin bundle as sampled from outside the clock domain
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] cs;
  } see_pins_t;

endpackage : see_pkg
